// file: eirq_pkg.sv
// eirq_pkg: constants, state codes and helpers of the external interrupt
// routing block.
// assumes: shared by eirq_top, eirq_sync and eirq_pic.
`default_nettype none

package eirq_pkg;

    // vector bases of the two cascaded controllers, and the nmi vector
    localparam logic [7:0] MASTER_BASE = 8'h40;
    localparam logic [7:0] SLAVE_BASE  = 8'h48;
    localparam logic [7:0] NMI_VEC     = 8'h02;

    // master request line positions
    localparam logic [2:0] M_LINE_HI0     = 3'h1;
    localparam logic [2:0] M_LINE_CASCADE = 3'h2;
    localparam logic [2:0] M_LINE_HI8     = 3'h3;
    localparam logic [2:0] M_LINE_HI9     = 3'h4;
    localparam logic [2:0] M_LINE_HI1     = 3'h5;
    localparam logic [2:0] M_LINE_HI2     = 3'h6;
    localparam logic [2:0] M_LINE_HI3     = 3'h7;

    // slave request line positions
    localparam logic [2:0] S_LINE_LO4 = 3'h0;
    localparam logic [2:0] S_LINE_LO5 = 3'h1;
    localparam logic [2:0] S_LINE_LO6 = 3'h4;
    localparam logic [2:0] S_LINE_LO7 = 3'h6;
    localparam logic [2:0] S_LINE_WDT = 3'h7;

    // line whose vector also marks an invalid request
    localparam logic [2:0] SPURIOUS_LINE = 3'h7;

    // reset values
    localparam logic [7:0] LINES_RST = 8'h00;
    localparam logic [7:0] VEC_RST   = 8'h00;

    // answer sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ANSWER = 2'b10
    } eirq_state_e;

    // vector of a line under a controller base
    function automatic logic [7:0] eirq_vec(input logic [7:0] base,
                                            input logic [2:0] line);
        eirq_vec = base | {5'h00, line};
    endfunction : eirq_vec

    // lowest set bit: {found, index}; line 0 has top priority
    function automatic logic [3:0] eirq_first(input logic [7:0] v);
        eirq_first = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                eirq_first = {1'b1, 3'(i)};
            end
        end
    endfunction : eirq_first

endpackage : eirq_pkg

`default_nettype wire

// file: eirq_sync.sv
// eirq_sync: three-stage pin synchroniser with agreement filter and
// active-edge detector for a group of interrupt pins.
// assumes: pins asynchronous to clk; ACTIVE_LOW picks the active edge.
`timescale 1ns/1ps
`default_nettype none

module eirq_sync
    import eirq_pkg::*;
#(
    parameter int   W          = 1,
    parameter logic ACTIVE_LOW = 1'b0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // pins and request events
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] ev
);

    // idle level of the pins, a constant for reset
    localparam logic [W-1:0] IDLE = {W{ACTIVE_LOW}};

    typedef struct packed {
        logic [W-1:0] s1;   // first stage, read only by s2
        logic [W-1:0] s2;   // second stage
        logic [W-1:0] s3;   // third stage
        logic [W-1:0] lvl;  // filtered level
        logic [W-1:0] ev;   // one-cycle active-edge event
    } eirq_sync_s;

    eirq_sync_s st_q;
    eirq_sync_s st_d;
    logic [W-1:0] act_d;    // next level, active high
    logic [W-1:0] act_q;    // present level, active high

    // filter: level follows only when stages two and three agree
    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.lvl[i] = st_q.s3[i];
            end
        end
        act_d = ACTIVE_LOW ? ~st_d.lvl : st_d.lvl;
        act_q = ACTIVE_LOW ? ~st_q.lvl : st_q.lvl;
        st_d.ev = act_d & ~act_q;  // see [R11] see [R12]
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{s1: IDLE, s2: IDLE, s3: IDLE, lvl: IDLE, ev: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign ev = st_q.ev;

    // an event only follows an inactive-to-active level change
    property p_edge_only;
        @(posedge clk) disable iff (!rst_n)
        (st_q.ev != '0) |->
            ((st_q.ev & act_q & ~$past(act_q)) == st_q.ev);
    endproperty
    a_edge_only: assert property (p_edge_only) // see [R11] see [R12]
        else $error("interrupt event without an active edge");

endmodule : eirq_sync

`default_nettype wire

// file: eirq_pic.sv
// eirq_pic: eight-line vectored priority controller with request and
// in-service bits, fixed priority, spurious answer on line seven.
// assumes: req are one-cycle events, lvl are steady levels, ack and eoi
// are one-cycle pulses, ack from the answer sequencer, eoi from the core.
`timescale 1ns/1ps
`default_nettype none

module eirq_pic
    import eirq_pkg::*;
#(
    parameter logic [7:0] BASE = 8'h00
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // requests
    input  wire logic [7:0] req,
    input  wire logic [7:0] lvl,
    input  wire logic [7:0] mask,
    // answer control
    input  wire logic       ack,
    input  wire logic       eoi,
    // status
    output logic            int_o,
    output logic            sel_valid,
    output logic [2:0]      sel,
    output logic [7:0]      vec,
    output logic [7:0]      isr
);

    typedef struct packed {
        logic [7:0] irr;    // latched requests
        logic [7:0] isr;    // lines in service
    } eirq_pic_s;

    eirq_pic_s  st_q;
    eirq_pic_s  st_d;
    logic [7:0] pend;       // unmasked pending lines
    logic [7:0] allow;      // lines above the highest in service
    logic [3:0] pick;       // chosen pending line
    logic [3:0] top_isr;    // highest line in service

    // selection and next state
    always_comb begin
        st_d    = st_q;
        top_isr = eirq_first(st_q.isr);
        allow   = top_isr[3] ? ((8'h01 << top_isr[2:0]) - 8'h01) : 8'hff;
        pend    = (st_q.irr | lvl) & ~mask & allow;
        pick    = eirq_first(pend);
        // end of interrupt clears the highest bit in service
        if (eoi && top_isr[3]) begin
            st_d.isr[top_isr[2:0]] = 1'b0;
        end
        // ack moves the chosen line into service
        if (ack && pick[3]) begin
            st_d.irr[pick[2:0]] = 1'b0;
            st_d.isr[pick[2:0]] = 1'b1;
        end
        // spurious ack leaves line seven out of service, see [R14]
        st_d.irr = st_d.irr | req;  // new event wins over the clear
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{irr: LINES_RST, isr: LINES_RST};
        end else begin
            st_q <= st_d;
        end
    end

    // outputs: handshake level, selection and vector are combinational
    assign int_o     = pick[3];
    assign sel_valid = pick[3];
    assign sel       = pick[2:0];
    assign vec       = pick[3] ? eirq_vec(BASE, pick[2:0])
                               : eirq_vec(BASE, SPURIOUS_LINE); // see [R13]
    assign isr       = st_q.isr;

    // a spurious ack never puts line seven in service
    property p_spur_isr;
        @(posedge clk) disable iff (!rst_n)
        (ack && !pick[3] && !st_q.isr[SPURIOUS_LINE]) |=>
            !st_q.isr[SPURIOUS_LINE];
    endproperty
    a_spur_isr: assert property (p_spur_isr) // see [R14]
        else $error("spurious ack set line seven in service");

endmodule : eirq_pic

`default_nettype wire

// file: eirq_top.sv
// eirq_top: routes external interrupt pins into a cascaded master and
// slave vectored controller and answers the core's vector fetch.
// assumes: core pulses INT_ACK for one cycle and samples VECTOR_Q while
// VECTOR_VALID is high; EOI pulses end service on one controller.
//
// Contract
// [R1] master takes six active-high inputs, four on port3
// [R2] high inputs zero, one, two: 0x41, 0x45, 0x46
// [R3] high input three: 0x47 on line seven
// [R4] high input eight: 0x43, shared with serial one
// [R5] high input nine: 0x44, shared with serial zero
// [R6] slave low inputs four, five: 0x48, 0x49
// [R7] slave low inputs six, seven: 0x4c, 0x4e
// [R8] low inputs are dedicated, unmultiplexed pins
// [R9] watchdog timeout delivers vector 0x4f
// [R10] nmi rising edge, vector 0x2, never masked
// [R11] high inputs request only on rising edge
// [R12] low inputs request only on falling edge
// [R13] invalid request answers with line seven vector
// [R14] spurious answer leaves line seven not in service
// [R15] line seven handler checks in-service bit
// [R16] low input five serves optional serial controller
// [R17] slave request cascades through a master line
`timescale 1ns/1ps
`default_nettype none

module eirq_top
    import eirq_pkg::*;
(
    // clock and reset
    input  wire logic       CORE_CLK,
    input  wire logic       RSTN,
    // active-high pins; zero to three ride port3_bit2 to port3_bit5
    input  wire logic       HIGH_IRQ_IN_ZERO,
    input  wire logic       HIGH_IRQ_IN_ONE,
    input  wire logic       HIGH_IRQ_IN_TWO,
    input  wire logic       HIGH_IRQ_IN_THREE,
    input  wire logic       HIGH_IRQ_IN_EIGHT,
    input  wire logic       HIGH_IRQ_IN_NINE,
    // dedicated active-low pins
    input  wire logic       LOW_IRQ_IN_FOUR,
    input  wire logic       LOW_IRQ_IN_FIVE,
    input  wire logic       LOW_IRQ_IN_SIX,
    input  wire logic       LOW_IRQ_IN_SEVEN,
    // optional on-board serial controller on low input five
    input  wire logic       OPT_SERIAL_FITTED,
    input  wire logic       OPT_SERIAL_IRQ_N,
    // on-chip sources, same clock
    input  wire logic       SERIAL_CHANNEL_ZERO_IRQ,
    input  wire logic       SERIAL_CHANNEL_ONE_IRQ,
    input  wire logic       WATCHDOG_TIMEOUT_IRQ,
    // non-maskable pin
    input  wire logic       NMI_IN,
    // masks, one bit per line, high masks
    input  wire logic [7:0] MASTER_MASK,
    input  wire logic [7:0] SLAVE_MASK,
    // core side
    input  wire logic       INT_ACK,
    input  wire logic       EOI_MASTER,
    input  wire logic       EOI_SLAVE,
    output logic            INTR,
    output logic            NMI_REQ,
    output logic [7:0]      VECTOR_Q,
    output logic            VECTOR_VALID,
    output logic [7:0]      MASTER_IN_SERVICE,
    output logic [7:0]      SLAVE_IN_SERVICE
);

    typedef struct packed {
        eirq_state_e st;        // answer sequencer
        logic        nmi;       // nmi pending
        logic [7:0]  vec;       // vector held for the core
        logic        ser0;      // previous serial zero level
        logic        ser1;      // previous serial one level
        logic        wdt;       // previous watchdog level
    } eirq_top_s;

    eirq_top_s  st_q;
    eirq_top_s  st_d;
    logic [6:0] hi_ev;          // high-pin and nmi events
    logic [3:0] lo_ev;          // low-pin events
    logic       lo5_pin;        // low input five source
    logic [7:0] m_req;          // master request events
    logic [7:0] s_req;          // slave request events
    logic [7:0] m_lvl;          // master level inputs
    logic       s_int;          // slave combined request
    logic       m_int;          // master request to core
    logic       m_valid;        // master has a line to give
    logic [2:0] m_sel;          // master chosen line
    logic [7:0] m_vec;          // master vector
    logic       s_valid;        // slave has a line to give
    logic [2:0] s_sel;          // slave chosen line
    logic [7:0] s_vec;          // slave vector
    logic       take;           // ack accepted this cycle
    logic       m_ack;          // ack to master
    logic       s_ack;          // ack to slave
    logic       ser0_ev;        // serial zero rising edge
    logic       ser1_ev;        // serial one rising edge
    logic       wdt_ev;         // watchdog rising edge

    // fitted serial controller takes over low input five, see [R16]
    assign lo5_pin = OPT_SERIAL_FITTED ? OPT_SERIAL_IRQ_N : LOW_IRQ_IN_FIVE;

    // active-high pins and nmi: rising edges only
    eirq_sync #(
        .W          (7),
        .ACTIVE_LOW (1'b0)
    ) u_hi_sync (
        .clk (CORE_CLK),
        .rst_n (RSTN),
        .pin ({NMI_IN, HIGH_IRQ_IN_NINE, HIGH_IRQ_IN_EIGHT,
               HIGH_IRQ_IN_THREE, HIGH_IRQ_IN_TWO, HIGH_IRQ_IN_ONE,
               HIGH_IRQ_IN_ZERO}),
        .ev  (hi_ev)
    );

    // dedicated active-low pins: falling edges only, see [R8]
    eirq_sync #(
        .W          (4),
        .ACTIVE_LOW (1'b1)
    ) u_lo_sync (
        .clk (CORE_CLK),
        .rst_n (RSTN),
        .pin ({LOW_IRQ_IN_SEVEN, LOW_IRQ_IN_SIX, lo5_pin,
               LOW_IRQ_IN_FOUR}),
        .ev  (lo_ev)
    );

    // rising edges of on-chip sources
    assign ser0_ev = SERIAL_CHANNEL_ZERO_IRQ & ~st_q.ser0;
    assign ser1_ev = SERIAL_CHANNEL_ONE_IRQ & ~st_q.ser1;
    assign wdt_ev  = WATCHDOG_TIMEOUT_IRQ & ~st_q.wdt;

    // master line map
    always_comb begin
        m_req                 = LINES_RST;
        m_req[M_LINE_HI0]     = hi_ev[0];           // see [R1] see [R2]
        m_req[M_LINE_HI1]     = hi_ev[1];           // see [R2]
        m_req[M_LINE_HI2]     = hi_ev[2];           // see [R2]
        m_req[M_LINE_HI3]     = hi_ev[3];           // see [R3]
        m_req[M_LINE_HI8]     = hi_ev[4] | ser1_ev; // see [R4]
        m_req[M_LINE_HI9]     = hi_ev[5] | ser0_ev; // see [R5]
        m_lvl                 = LINES_RST;
        m_lvl[M_LINE_CASCADE] = s_int;              // see [R17]
    end

    // slave line map
    always_comb begin
        s_req             = LINES_RST;
        s_req[S_LINE_LO4] = lo_ev[0];   // see [R6]
        s_req[S_LINE_LO5] = lo_ev[1];   // see [R6]
        s_req[S_LINE_LO6] = lo_ev[2];   // see [R7]
        s_req[S_LINE_LO7] = lo_ev[3];   // see [R7]
        s_req[S_LINE_WDT] = wdt_ev;     // see [R9]
    end

    // master controller
    eirq_pic #(
        .BASE (MASTER_BASE)
    ) u_master (
        .clk       (CORE_CLK),
        .rst_n     (RSTN),
        .req       (m_req),
        .lvl       (m_lvl),
        .mask      (MASTER_MASK),
        .ack       (m_ack),
        .eoi       (EOI_MASTER),
        .int_o     (m_int),
        .sel_valid (m_valid),
        .sel       (m_sel),
        .vec       (m_vec),
        .isr       (MASTER_IN_SERVICE)
    );

    // slave controller
    eirq_pic #(
        .BASE (SLAVE_BASE)
    ) u_slave (
        .clk       (CORE_CLK),
        .rst_n     (RSTN),
        .req       (s_req),
        .lvl       (LINES_RST),
        .mask      (SLAVE_MASK),
        .ack       (s_ack),
        .eoi       (EOI_SLAVE),
        .int_o     (s_int),
        .sel_valid (s_valid),
        .sel       (s_sel),
        .vec       (s_vec),
        .isr       (SLAVE_IN_SERVICE)
    );

    // ack routing: nmi first, else master, slave through cascade line
    assign take  = INT_ACK && (st_q.st == ST_IDLE);
    assign m_ack = take && !st_q.nmi;
    assign s_ack = m_ack && m_valid && (m_sel == M_LINE_CASCADE);

    // answer sequencer and pending nmi
    always_comb begin
        st_d      = st_q;
        st_d.ser0 = SERIAL_CHANNEL_ZERO_IRQ;
        st_d.ser1 = SERIAL_CHANNEL_ONE_IRQ;
        st_d.wdt  = WATCHDOG_TIMEOUT_IRQ;
        case (st_q.st)
            ST_IDLE: begin
                if (take) begin
                    st_d.st = ST_ANSWER;
                    if (st_q.nmi) begin
                        st_d.vec = NMI_VEC;     // see [R10]
                        st_d.nmi = 1'b0;
                    end else if (s_ack) begin
                        st_d.vec = s_vec;       // see [R17]
                    end else begin
                        st_d.vec = m_vec;       // see [R13]
                    end
                end
            end
            ST_ANSWER: begin
                st_d.st = ST_IDLE;              // one-cycle answer
            end
            default: begin
                st_d.st = ST_IDLE;
            end
        endcase
        // nmi edge ignores masks and wins over its clear, see [R10]
        if (hi_ev[6]) begin
            st_d.nmi = 1'b1;
        end
    end

    // state register
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_q <= '{st: ST_IDLE, nmi: 1'b0, vec: VEC_RST,
                      ser0: 1'b0, ser1: 1'b0, wdt: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // outputs
    assign INTR         = m_int;
    assign NMI_REQ      = st_q.nmi;
    assign VECTOR_Q     = st_q.vec;
    assign VECTOR_VALID = (st_q.st == ST_ANSWER);

    // assertions
    sequence s_take_master;
        take && !st_q.nmi;
    endsequence

    sequence s_answer;
        VECTOR_VALID ##1 !VECTOR_VALID;
    endsequence

    property p_answer;
        @(posedge CORE_CLK) disable iff (!RSTN)
        take |=> s_answer;
    endproperty
    a_answer: assert property (p_answer) // see [R17]
        else $error("ack not answered for exactly one cycle");

    property p_vec_hi0;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (s_take_master and (m_valid && m_sel == M_LINE_HI0)) |=>
            (VECTOR_Q == 8'h41);
    endproperty
    a_vec_hi0: assert property (p_vec_hi0) // see [R2]
        else $error("high input zero vector wrong");

    property p_vec_hi3;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (s_take_master and (m_valid && m_sel == M_LINE_HI3)) |=>
            (VECTOR_Q == 8'h47) && MASTER_IN_SERVICE[SPURIOUS_LINE];
    endproperty
    a_vec_hi3: assert property (p_vec_hi3) // see [R3]
        else $error("high input three vector or service bit wrong");

    property p_vec_hi8;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (s_take_master and (m_valid && m_sel == M_LINE_HI8)) |=>
            (VECTOR_Q == 8'h43);
    endproperty
    a_vec_hi8: assert property (p_vec_hi8) // see [R4]
        else $error("high input eight vector wrong");

    property p_vec_hi9;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (s_take_master and (m_valid && m_sel == M_LINE_HI9)) |=>
            (VECTOR_Q == 8'h44);
    endproperty
    a_vec_hi9: assert property (p_vec_hi9) // see [R5]
        else $error("high input nine vector wrong");

    property p_vec_slave;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (s_ack && s_valid) |=>
            (VECTOR_Q == eirq_vec(SLAVE_BASE, $past(s_sel)));
    endproperty
    a_vec_slave: assert property (p_vec_slave) // see [R6] see [R7] see [R9]
        else $error("slave vector does not match its line");

    property p_spurious;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (s_take_master and !m_valid) |=> (VECTOR_Q == 8'h47);
    endproperty
    a_spurious: assert property (p_spurious) // see [R13]
        else $error("spurious answer is not the line seven vector");

    property p_nmi;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (take && st_q.nmi) |=> (VECTOR_Q == NMI_VEC) ##1 !VECTOR_VALID;
    endproperty
    a_nmi: assert property (p_nmi) // see [R10]
        else $error("nmi answer wrong");

    property p_nmi_set;
        @(posedge CORE_CLK) disable iff (!RSTN)
        hi_ev[6] |=> NMI_REQ;
    endproperty
    a_nmi_set: assert property (p_nmi_set) // see [R10]
        else $error("nmi edge lost");

endmodule : eirq_top

`default_nettype wire

// file: eirq_pins.sv
// eirq_pins: model of the external interrupt sources wired to the pins.
// assumes: driven by tb through its pulse task; changes on falling edge.
`timescale 1ns/1ps
`default_nettype none

module eirq_pins (
    // clock
    input  wire logic       clk,
    // pins: high group, low group (bit 4 = optional serial), nmi
    output logic      [5:0] hi,
    output logic      [4:0] lo_n,
    output logic            nmi
);
    // idle: pull-downs on high pins and nmi, low pins held high
    initial begin
        hi   = 6'h00;
        lo_n = 5'h1f;
        nmi  = 1'b0;
    end

    // one request: active edge, hold, release; 0..5 high, 6..10 low, 11 nmi
    task automatic pulse(input int idx);
        @(negedge clk);
        if (idx < 6) begin
            hi[idx] = 1'b1;
        end else if (idx < 11) begin
            lo_n[idx-6] = 1'b0;
        end else begin
            nmi = 1'b1;
        end
        repeat (6) @(negedge clk);
        hi   = 6'h00;
        lo_n = 5'h1f;
        nmi  = 1'b0;
        repeat (6) @(negedge clk);
    endtask : pulse
endmodule : eirq_pins

`default_nettype wire

// file: tb.sv
// tb: self-checking bench of the external interrupt routing block.
// assumes: pins come from eirq_pins; core side is driven here.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic       clk, rstn, fit, nmi, ack_r, eoim, eois;
    logic [5:0] hi;
    logic [4:0] lo_n;
    logic [2:0] onc;            // serial one, serial zero, watchdog
    logic [7:0] mm, sm, vq, mis, sis;
    logic       intr, nmi_req, vv;
    int         mismatches, cmp_count, cycles;
    // expected vectors and lines of the high and low pins
    logic [7:0] hv [6] = '{8'h41, 8'h45, 8'h46, 8'h47, 8'h43, 8'h44};
    logic [2:0] hl [6] = '{3'h1, 3'h5, 3'h6, 3'h7, 3'h3, 3'h4};
    logic [7:0] lv [4] = '{8'h48, 8'h49, 8'h4c, 8'h4e};
    logic [2:0] ll [4] = '{3'h0, 3'h1, 3'h4, 3'h6};
    logic [7:0] ov [3] = '{8'h43, 8'h44, 8'h4f};
    // expected master in-service of the on-chip sources
    logic [7:0] om [3] = '{8'h08, 8'h10, 8'h04};

    eirq_pins i_eirq_pins (.clk(clk), .hi(hi), .lo_n(lo_n), .nmi(nmi));

    eirq_top i_eirq_top (
        .CORE_CLK(clk), .RSTN(rstn),
        .HIGH_IRQ_IN_ZERO(hi[0]), .HIGH_IRQ_IN_ONE(hi[1]),
        .HIGH_IRQ_IN_TWO(hi[2]), .HIGH_IRQ_IN_THREE(hi[3]),
        .HIGH_IRQ_IN_EIGHT(hi[4]), .HIGH_IRQ_IN_NINE(hi[5]),
        .LOW_IRQ_IN_FOUR(lo_n[0]), .LOW_IRQ_IN_FIVE(lo_n[1]),
        .LOW_IRQ_IN_SIX(lo_n[2]), .LOW_IRQ_IN_SEVEN(lo_n[3]),
        .OPT_SERIAL_FITTED(fit), .OPT_SERIAL_IRQ_N(lo_n[4]),
        .SERIAL_CHANNEL_ZERO_IRQ(onc[1]), .SERIAL_CHANNEL_ONE_IRQ(onc[0]),
        .WATCHDOG_TIMEOUT_IRQ(onc[2]), .NMI_IN(nmi),
        .MASTER_MASK(mm), .SLAVE_MASK(sm),
        .INT_ACK(ack_r), .EOI_MASTER(eoim), .EOI_SLAVE(eois),
        .INTR(intr), .NMI_REQ(nmi_req), .VECTOR_Q(vq),
        .VECTOR_VALID(vv), .MASTER_IN_SERVICE(mis),
        .SLAVE_IN_SERVICE(sis));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            mismatches++;
            finish_test();
        end
    end

    // compare and count
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // core vector fetch: one-cycle ack, one-cycle valid
    task automatic ack(input logic [7:0] exp);
        int n;
        n = 0;
        @(negedge clk) ack_r = 1'b1;
        @(negedge clk) ack_r = 1'b0;
        while (vv !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        check("valid", 8'(vv), 8'h01);
        check("vector", vq, exp);
        @(negedge clk);
        check("valid width", 8'(vv), 8'h00);
    endtask : ack

    // end of service on both controllers
    task automatic eoi();
        @(negedge clk) {eoim, eois} = 2'b11;
        @(negedge clk) {eoim, eois} = 2'b00;
    endtask : eoi

    // ack with nothing pending gives the line seven vector, not in service
    task automatic t_spurious();
        ack(8'h47);
        check("master isr", mis, 8'h00);
    endtask : t_spurious

    // each high pin: one request, own vector and line, release is ignored
    task automatic t_high();
        for (int i = 0; i < 6; i++) begin
            i_eirq_pins.pulse(i);
            check("intr", 8'(intr), 8'h01);
            ack(hv[i]);
            check("master isr", mis, 8'h01 << hl[i]);
            eoi();
            check("intr idle", 8'(intr), 8'h00);
        end
    endtask : t_high

    // each low pin through the slave, cascaded on master line two
    task automatic t_low();
        for (int i = 0; i < 4; i++) begin
            i_eirq_pins.pulse(6 + i);
            ack(lv[i]);
            check("slave isr", sis, 8'h01 << ll[i]);
            check("master isr", mis, 8'h04);
            eoi();
            check("intr idle", 8'(intr), 8'h00);
        end
    endtask : t_low

    // serial channels share the master lines of high pins eight and nine; watchdog has slave line seven
    task automatic t_onchip();
        for (int i = 0; i < 3; i++) begin
            @(negedge clk) onc[i] = 1'b1;
            repeat (3) @(negedge clk);
            onc[i] = 1'b0;
            ack(ov[i]);
            check("master isr", mis, om[i]);
            check("slave isr", sis, (i == 2) ? 8'h80 : 8'h00);
            eoi();
        end
    endtask : t_onchip

    // nmi passes full masks; masked line stays latched until unmasked
    task automatic t_nmi();
        mm = 8'hff;
        sm = 8'hff;
        i_eirq_pins.pulse(0);
        i_eirq_pins.pulse(11);
        check("nmi req", 8'(nmi_req), 8'h01);
        check("intr masked", 8'(intr), 8'h00);
        ack(8'h02);
        check("nmi cleared", 8'(nmi_req), 8'h00);
        ack(8'h47);
        @(negedge clk) mm = 8'h00;
        sm = 8'h00;
        @(negedge clk);
        ack(8'h41);
        eoi();
    endtask : t_nmi

    // fitted serial part takes over low input five
    task automatic t_opt();
        @(negedge clk) rstn = 1'b0;
        fit = 1'b1;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        i_eirq_pins.pulse(7);
        check("pin five ignored", 8'(intr), 8'h00);
        i_eirq_pins.pulse(10);
        ack(8'h49);
    endtask : t_opt

    // counts, verdict, stop
    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // main sequence
    initial begin
        {rstn, fit, ack_r, eoim, eois} = 5'h00;
        {onc, mm, sm} = 19'h0;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        t_spurious();
        t_high();
        t_low();
        t_onchip();
        t_nmi();
        t_opt();
        finish_test();
    end
endmodule : tb

`default_nettype wire
